//--- pkg/mmst_pkg.sv
// mmst_pkg: constants, register map and types of the module status and timing block
package mmst_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int T_INIT_MS       = 2000;
   localparam int T_RESET_MIN_US  = 2;
   // least time: round up
   localparam int RESET_MIN_CYC   = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest time: round down
   localparam int INIT_CYC        = int'((64'(T_INIT_MS) * 64'h0f4240) / 64'(CLK_PERIOD_NS));

   // ----------------------------------------------------------------
   // synchronised pins
   // ----------------------------------------------------------------
   localparam int PIN_W   = 4;
   localparam int PIN_RST = 0;
   localparam int PIN_SEL = 1;
   localparam int PIN_LP  = 2;
   localparam int PIN_SCL = 3;
   localparam logic [PIN_W-1:0] PIN_IDLE = 4'hb;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_FLAGS   = 8'h04;
   localparam logic [7:0] ADDR_MASK    = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;

   // fields
   localparam int FLAG_W      = 8;
   localparam int COND_W      = 5;
   localparam int FLAG_RXLOS  = 0;
   localparam int FLAG_TXF    = 1;
   localparam int FLAG_READY  = 7;
   localparam int CTRL_PDOWN  = 0;
   localparam int IRQ_W       = 4;
   localparam logic [FLAG_W-1:0] FLAGS_ALL = 8'hff;

   typedef enum logic [3:0] {
      MMST_ST_HOLD   = 4'b0001,
      MMST_ST_INIT   = 4'b0010,
      MMST_ST_READY  = 4'b0100,
      MMST_ST_LOWPWR = 4'b1000
   } mmst_state_t;

endpackage

//--- pkg/mmst_pin_if.sv
// mmst_pin_if: raw pins in, filtered levels and edges out
`timescale 1ns/10ps
interface mmst_pin_if;
   logic [mmst_pkg::PIN_W-1:0] raw;
   logic [mmst_pkg::PIN_W-1:0] level;
   logic [mmst_pkg::PIN_W-1:0] rise;
   logic [mmst_pkg::PIN_W-1:0] fall;
   modport sync (input raw, output level, output rise, output fall);
   modport user (output raw, input level, input rise, input fall);
endinterface

//--- hw/mmst_pin_sync.sv
// mmst_pin_sync: three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module mmst_pin_sync (
   // clock and reset
   input  wire logic     pclk,
   input  wire logic     presetn,
   // pins
   mmst_pin_if.sync      pin
);
   import mmst_pkg::*;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_bit
         logic s1_ff, s2_ff, s3_ff;
         logic lvl_ff, rise_ff, fall_ff;
         wire  agree = (s2_ff == s3_ff);

         // first stage feeds only the second
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_ff   <= PIN_IDLE[gi];
               s2_ff   <= PIN_IDLE[gi];
               s3_ff   <= PIN_IDLE[gi];
               lvl_ff  <= PIN_IDLE[gi];
               rise_ff <= 1'b0;
               fall_ff <= 1'b0;
            end else begin
               s1_ff   <= pin.raw[gi];
               s2_ff   <= s1_ff;
               s3_ff   <= s2_ff;
               lvl_ff  <= agree ? s2_ff : lvl_ff;
               rise_ff <= agree & s2_ff & ~lvl_ff;
               fall_ff <= agree & ~s2_ff & lvl_ff;
            end
         end

         assign pin.level[gi] = lvl_ff;
         assign pin.rise[gi]  = rise_ff;
         assign pin.fall[gi]  = fall_ff;
      end
   endgenerate

endmodule

//--- hw/mmst_status_ctrl.sv
// mmst_status_ctrl: init, reset-pin, flag, attention, select and low-power control
//
// Operation
// [R1] become fully functional within 2000 ms of power-on, insertion or reset rise
// [R2] reset pin counts only when held low longer than 2 us
// [R3] within 2000 ms of power-on clear data-not-ready and assert attention
// [R4] after reset pin returns high reach fully functional within 2000 ms
// [R5] fully functional means data-not-ready cleared and attention raised for it
// [R6] low-power request pin high enters reduced power within 100 us
// [R7] any attention condition drives attention line low within 200 ms
// [R8] reading a flag clears it; attention released within 500 us after clock fall
// [R9] receive loss sets its flag and attention within 100 ms
// [R10] transmit fault sets its flag and attention within 200 ms
// [R11] other conditions set their flag and attention within 200 ms
// [R12] setting a mask bit stops that flag's attention within 100 ms
// [R13] clearing a mask bit resumes that flag's attention within 100 ms
// [R14] select line low starts serial bus responses within 100 us
// [R15] select line released stops serial bus responses within 100 us
// [R16] power-down bit set enters reduced power within 100 ms
// [R17] power-down bit cleared returns to fully functional within 300 ms
// [R18] write effects count from the serial clock fall after the write
// [R19] flags latch until read even if the condition has gone
`timescale 1ns/10ps
module mmst_status_ctrl #(
   parameter int INIT_CYCLES = mmst_pkg::INIT_CYC
) (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // module pins
   input  wire logic                          module_reset_line_n,
   input  wire logic                          module_select_line_n,
   input  wire logic                          low_power_request_pin,
   input  wire logic                          serial_clk_pin,
   output logic                               attention_line_n_o,
   output logic                               attention_line_n_oe,
   // device conditions
   input  wire logic                          rx_los_cond,
   input  wire logic                          tx_fault_cond,
   input  wire logic [mmst_pkg::COND_W-1:0]   other_cond,
   // status outputs
   output logic                               serial_respond_en,
   output logic                               low_power_mode,
   output logic                               irq
);
   import mmst_pkg::*;

   localparam logic [7:0]  RST_CNT_TOP = 8'(RESET_MIN_CYC + 1);
   localparam logic [31:0] INIT_LAST   = 32'(INIT_CYCLES - 1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   mmst_pin_if pins ();

   assign pins.raw = {serial_clk_pin, low_power_request_pin,
                      module_select_line_n, module_reset_line_n};

   mmst_pin_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (pins.sync)
   );

   wire rst_n_level = pins.level[PIN_RST];
   wire sel_n_level = pins.level[PIN_SEL];
   wire lp_level    = pins.level[PIN_LP];
   wire scl_fall    = pins.fall[PIN_SCL];

   // ----------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------
   mmst_state_t       state_ff, nxt_state;
   logic [7:0]        rst_cnt_ff;
   logic [31:0]       init_cnt_ff;
   logic              dnr_ff;
   logic [FLAG_W-1:0] flags_ff, nxt_flags;
   logic [FLAG_W-1:0] rd_clr_pend_ff;
   logic [FLAG_W-1:0] mask_wr_ff, mask_ff;
   logic              pdown_wr_ff, pdown_ff;
   logic              attn_ff;
   logic              respond_ff;
   logic              lowpwr_ff;
   logic [IRQ_W-1:0]  irq_st_ff, irq_en_ff;
   logic [31:0]       prdata_ff;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire hit_st   = (paddr == ADDR_STATUS);
   wire hit_fl   = (paddr == ADDR_FLAGS);
   wire hit_mk   = (paddr == ADDR_MASK);
   wire hit_ct   = (paddr == ADDR_CONTROL);
   wire hit_ist  = (paddr == ADDR_IRQ_ST);
   wire hit_ien  = (paddr == ADDR_IRQ_EN);
   wire hit_icl  = (paddr == ADDR_IRQ_CLR);
   wire hit_any  = hit_st | hit_fl | hit_mk | hit_ct | hit_ist | hit_ien | hit_icl;
   wire wr_acc   = access & pwrite & hit_any;
   wire rd_fl    = access & ~pwrite & hit_fl;

   // read data latched in setup so access phase always answers at once
   wire [31:0] rd_mux =
      hit_st  ? {24'h000000, state_ff, 1'b0, respond_ff, lowpwr_ff, dnr_ff} :
      hit_fl  ? {24'h000000, flags_ff} :
      hit_mk  ? {24'h000000, mask_wr_ff} :
      hit_ct  ? {31'h00000000, pdown_wr_ff} :
      hit_ist ? {28'h0000000, irq_st_ff} :
      hit_ien ? {28'h0000000, irq_en_ff} :
                32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = access & ~hit_any;
   assign prdata  = prdata_ff;

   // ----------------------------------------------------------------
   // reset pin filter and state machine
   // ----------------------------------------------------------------
   wire rst_seen   = ~rst_n_level & (rst_cnt_ff == RST_CNT_TOP); // R2
   wire init_done  = (state_ff == MMST_ST_INIT) & (init_cnt_ff == INIT_LAST);
   wire lp_req     = lp_level | pdown_ff;
   wire ready_like = (state_ff == MMST_ST_READY) | (state_ff == MMST_ST_LOWPWR);

   // low time is counted on the filtered level, so single-sample glitches never start it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_ff <= 8'h00;
      end else if (rst_n_level) begin
         rst_cnt_ff <= 8'h00;
      end else if (rst_cnt_ff != RST_CNT_TOP) begin
         rst_cnt_ff <= rst_cnt_ff + 8'h01; // R2
      end
   end

   // next state; a recognised reset overrides everything
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         MMST_ST_HOLD:   if (rst_n_level) nxt_state = MMST_ST_INIT; // R4
         MMST_ST_INIT:   if (init_done) nxt_state = MMST_ST_READY;  // R1
         MMST_ST_READY:  if (lp_req) nxt_state = MMST_ST_LOWPWR;    // R6 R16
         MMST_ST_LOWPWR: if (!lp_req) nxt_state = MMST_ST_READY;    // R17
         default:        nxt_state = MMST_ST_INIT;
      endcase
      if (rst_seen) begin
         nxt_state = MMST_ST_HOLD;
      end
   end

   // power-on release lands in init directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= MMST_ST_INIT;
         init_cnt_ff <= 32'h00000000;
         dnr_ff      <= 1'b1;
         lowpwr_ff   <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         init_cnt_ff <= (state_ff == MMST_ST_INIT) ? init_cnt_ff + 32'h00000001 : 32'h00000000;
         dnr_ff      <= (nxt_state == MMST_ST_HOLD) | (dnr_ff & ~init_done); // R3 R5
         lowpwr_ff   <= (nxt_state == MMST_ST_LOWPWR);
      end
   end

   // ----------------------------------------------------------------
   // flags, mask and attention line
   // ----------------------------------------------------------------
   wire [FLAG_W-1:0] flag_set  = {init_done, other_cond, tx_fault_cond, rx_los_cond}; // R9 R10 R11
   wire [FLAG_W-1:0] clr_now   = scl_fall ? rd_clr_pend_ff : '0;                     // R8
   wire              attn_act  = |(flags_ff & ~mask_ff);                             // R7 R12 R13
   wire              flag_new  = |(flag_set & ~flags_ff);

   // set wins over a clear in the same cycle; cleared while reset is recognised
   always_comb begin
      nxt_flags = (flags_ff & ~clr_now) | flag_set; // R19
      if (state_ff == MMST_ST_HOLD) begin
         nxt_flags = '0;
      end
   end

   // mask and control writes and read-clears take effect at the next serial clock fall;
   // a stopped clock leaves them pending, which is the intended timing origin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff       <= '0;
         rd_clr_pend_ff <= '0;
         mask_wr_ff     <= '0;
         mask_ff        <= '0;
         pdown_wr_ff    <= 1'b0;
         pdown_ff       <= 1'b0;
         attn_ff        <= 1'b0;
      end else begin
         flags_ff       <= nxt_flags;
         rd_clr_pend_ff <= (rd_clr_pend_ff & ~clr_now) | (rd_fl ? prdata_ff[FLAG_W-1:0] : '0);
         mask_wr_ff     <= (wr_acc & hit_mk) ? pwdata[FLAG_W-1:0] : mask_wr_ff;
         pdown_wr_ff    <= (wr_acc & hit_ct) ? pwdata[CTRL_PDOWN] : pdown_wr_ff;
         mask_ff        <= scl_fall ? mask_wr_ff : mask_ff;   // R18
         pdown_ff       <= scl_fall ? pdown_wr_ff : pdown_ff; // R18
         attn_ff        <= attn_act;
      end
   end

   // open drain: only ever pulls low
   assign attention_line_n_o  = 1'b0;
   assign attention_line_n_oe = attn_ff;

   // ----------------------------------------------------------------
   // serial bus gating, interrupt, read data
   // ----------------------------------------------------------------
   // low-power change taken from the next state: the registered copy always equals state_ff
   wire [IRQ_W-1:0] irq_evt = {(nxt_state == MMST_ST_LOWPWR) ^ lowpwr_ff, flag_new,
                               rst_seen & (state_ff != MMST_ST_HOLD), init_done};
   wire [IRQ_W-1:0] irq_clr = (wr_acc & hit_icl) ? pwdata[IRQ_W-1:0] : '0;

   // no bus responses until initialisation finishes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         respond_ff <= 1'b0;
         irq_st_ff  <= '0;
         irq_en_ff  <= '0;
         prdata_ff  <= 32'h00000000;
      end else begin
         respond_ff <= ~sel_n_level & ready_like; // R14 R15
         irq_st_ff  <= (irq_st_ff & ~irq_clr) | irq_evt;
         irq_en_ff  <= (wr_acc & hit_ien) ? pwdata[IRQ_W-1:0] : irq_en_ff;
         prdata_ff  <= setup ? rd_mux : prdata_ff;
      end
   end

   assign serial_respond_en = respond_ff;
   assign low_power_mode    = lowpwr_ff;
   assign irq               = |(irq_st_ff & irq_en_ff);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [31:0]       init_age_ff;
   logic [FLAG_W-1:0] kept_ff;

   // helper: cycles since leaving hold or power-on, and flags that must survive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_age_ff <= 32'h00000000;
         kept_ff     <= '0;
      end else begin
         init_age_ff <= (state_ff == MMST_ST_HOLD) ? 32'h00000000 : init_age_ff + 32'h00000001;
         kept_ff     <= flags_ff & ~clr_now;
      end
   end

   sequence s_commit_clear;
      scl_fall && ((flags_ff & ~rd_clr_pend_ff & ~mask_wr_ff) == '0) && (flag_set == '0);
   endsequence

   sequence s_quiet_next;
      ##1 (flag_set == '0) && (state_ff != MMST_ST_HOLD);
   endsequence

   sequence s_cond_hit;
      |(flag_set & ~mask_ff) && !scl_fall && (state_ff != MMST_ST_HOLD) && !rst_seen;
   endsequence

   rst_pulse_width_a: assert property ($rose(state_ff == MMST_ST_HOLD)
      |-> $past(rst_cnt_ff) == RST_CNT_TOP) // R2
      else $error("reset recognised before minimum low time");

   init_time_a: assert property (dnr_ff && (state_ff != MMST_ST_HOLD)
      |-> init_age_ff <= 32'(INIT_CYCLES)) // R1 R4
      else $error("initialisation took too long");

   ready_attn_a: assert property ($fell(dnr_ff) && !mask_ff[FLAG_READY]
      |-> ##[1:2] attention_line_n_oe) // R3 R5
      else $error("attention not raised when data became ready");

   flag_attn_a: assert property (s_cond_hit |-> ##2 attention_line_n_oe) // R7 R9 R10 R11
      else $error("attention not raised for a condition");

   attn_release_a: assert property (s_commit_clear ##0 s_quiet_next
      |-> ##1 !attention_line_n_oe) // R8
      else $error("attention not released after read clear");

   mask_block_a: assert property (scl_fall && (mask_wr_ff == FLAGS_ALL)
      |-> ##2 !attention_line_n_oe) // R12 R18
      else $error("masked flag still drives attention");

   mask_resume_a: assert property (scl_fall && !rst_seen && (state_ff != MMST_ST_HOLD)
      && |(flags_ff & ~mask_wr_ff & ~rd_clr_pend_ff) |-> ##2 attention_line_n_oe) // R13 R18
      else $error("attention not resumed after unmask");

   sel_on_a: assert property ($fell(sel_n_level) && ready_like && !rst_seen
      |=> serial_respond_en) // R14
      else $error("bus not enabled after select");

   sel_off_a: assert property ($rose(sel_n_level) |=> !serial_respond_en) // R15
      else $error("bus still enabled after deselect");

   lp_pin_a: assert property ($rose(lp_level) && (state_ff == MMST_ST_READY) && !rst_seen
      |=> low_power_mode) // R6
      else $error("low power not entered from pin");

   pdown_on_a: assert property (scl_fall && pdown_wr_ff && (state_ff == MMST_ST_READY)
      && !rst_seen ##1 !rst_seen |-> ##1 low_power_mode) // R16
      else $error("low power not entered from power-down bit");

   pdown_off_a: assert property (scl_fall && !pdown_wr_ff && (state_ff == MMST_ST_LOWPWR)
      && !rst_seen ##1 !lp_level && !rst_seen |-> ##1 (state_ff == MMST_ST_READY)) // R17
      else $error("not back to ready after power-down cleared");

   flag_latch_a: assert property ((state_ff != MMST_ST_HOLD)
      |=> ((flags_ff & kept_ff) == kept_ff)) // R19
      else $error("latched flag lost without a read");

   init_hold_a: assert property ((state_ff == MMST_ST_INIT) && !init_done && !rst_seen
      |=> (state_ff == MMST_ST_INIT)) // R1 R4
      else $error("initialisation left before its count ran out");

   ready_clean_a: assert property (ready_like |-> !dnr_ff) // R5
      else $error("data-not-ready still set in a ready state");

   hold_clear_a: assert property ((state_ff == MMST_ST_HOLD)
      |=> (flags_ff == '0) && dnr_ff) // R2
      else $error("flags or data-not-ready wrong while reset is recognised");

   respond_gate_a: assert property (serial_respond_en
      |-> ($past(sel_n_level) == 1'b0) && $past(ready_like)) // R14 R15
      else $error("bus answered while deselected or not ready");

   lowpwr_cause_a: assert property (low_power_mode |-> $past(lp_req)) // R6 R16
      else $error("low power without a request");

endmodule

//--- test/mmst_host_model.sv
// mmst_host_model: host side of the sideband pins and the 2-wire serial clock
`timescale 1ns/10ps
module mmst_host_model (
   // clock
   input  wire logic pclk,
   // sideband pins towards the device
   output logic      module_reset_line_n,
   output logic      module_select_line_n,
   output logic      low_power_request_pin,
   output logic      serial_clk_pin
);
   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // idle levels: selected, full power, serial clock parked high
   initial begin
      module_reset_line_n   = 1'b1;
      module_select_line_n  = 1'b0;
      low_power_request_pin = 1'b0;
      serial_clk_pin        = 1'b1;
   end

   // level pins change just after a clock edge
   task automatic set_pins(input logic sel_n, input logic lp);
      @(posedge pclk);
      module_select_line_n  <= sel_n;
      low_power_request_pin <= lp;
   endtask

   // reset pulse; only a pulse beyond the minimum width is a reset
   task automatic reset_pulse(input int cycles);
      @(posedge pclk);
      module_reset_line_n <= 1'b0;
      repeat (cycles) @(posedge pclk);
      module_reset_line_n <= 1'b1;
   endtask

   // one byte of serial clock at 400 ns; odd offset keeps it off the pclk phase
   task automatic frame();
      #37;
      repeat (9) begin
         serial_clk_pin = 1'b0;
         #200;
         serial_clk_pin = 1'b1;
         #200;
      end
   endtask
endmodule

//--- test/tb_module_mgmt_status_timing.sv
// tb_module_mgmt_status_timing: self-checking bench of the status and timing block
`timescale 1ns/10ps
module tb_module_mgmt_status_timing;
   import mmst_pkg::*;
   localparam int INIT_N = 200;
   localparam int LIMIT  = 30000;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rng;
   logic              rst_n, sel_n, lp, scl, att_o, att_oe, rx_los, tx_f, resp, lpm, irq;
   logic [COND_W-1:0] oth;
   logic [32:0]       exp_q[$];
   logic [32:0]       e;
   int                err_count, num_checks, cyc;
   // open-drain attention line with its pull-up
   wire               attention_line_n = att_oe ? att_o : 1'b1;

   mmst_status_ctrl #(.INIT_CYCLES(INIT_N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .module_reset_line_n(rst_n),
      .module_select_line_n(sel_n), .low_power_request_pin(lp), .serial_clk_pin(scl),
      .attention_line_n_o(att_o), .attention_line_n_oe(att_oe), .rx_los_cond(rx_los),
      .tx_fault_cond(tx_f), .other_cond(oth), .serial_respond_en(resp),
      .low_power_mode(lpm), .irq(irq));
   mmst_host_model host (.pclk(pclk), .module_reset_line_n(rst_n),
      .module_select_line_n(sel_n), .low_power_request_pin(lp), .serial_clk_pin(scl));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic tally_and_finish();
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] ex, input string what);
      num_checks++;
      if (got !== ex) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, ex);
      end
   endtask

   // one apb transfer after an idle edge, so psel is never driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] ex);
      @(posedge pclk);
      exp_q.push_back({err, ex});
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0, 1'b0, ex);
   endtask

   // serial frame, then back onto a clock edge
   task automatic commit();
      host.frame();
      @(posedge pclk);
   endtask

   // waits a bounded time for an output level: 0 attention, 1 respond, 2 low power, 3 irq
   task automatic wait_lvl(input int which, input logic v, input int lim);
      logic s;
      int   n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         case (which)
            0:       s = attention_line_n;
            1:       s = resp;
            2:       s = lpm;
            default: s = irq;
         endcase
      end while (s !== v && n < lim);
      check({31'h0, s}, {31'h0, v}, "output level");
   endtask

   task automatic pulse_cond(input logic [6:0] c, input int len);
      {oth, tx_f, rx_los} <= c;
      repeat (len) @(posedge pclk);
      {oth, tx_f, rx_los} <= 7'h00;
   endtask

   // ------------------------------------------------------------
   // watcher and timeout
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]}, "pslverr");
         if (pwrite === 1'b0)
            check(prdata, e[31:0], "read data");
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_count++;
         $display("[ERR] %0t run did not finish", $time);
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {oth, tx_f, rx_los} = 7'h00;
      presetn = 1'b0;
      rng = 32'h2;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_STATUS, 32'h21);
      rd(ADDR_MASK, 32'h0);
      rd(ADDR_CONTROL, 32'h0);
      rd(ADDR_IRQ_EN, 32'h0);
      apb(1'b1, 8'h1c, 32'hff, 1'b1, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, 1'b1, 32'h0);
      wait_lvl(0, 1'b0, INIT_N + 50);
      rd(ADDR_STATUS, 32'h44);
      rd(ADDR_IRQ_ST, 32'h5);
      wait_lvl(3, 1'b0, 1);
      wr(ADDR_IRQ_EN, 32'h1);
      wait_lvl(3, 1'b1, 4);
      wr(ADDR_IRQ_CLR, 32'h1);
      rd(ADDR_IRQ_CLR, 32'h0);
      wait_lvl(3, 1'b0, 4);
      rd(ADDR_FLAGS, 32'h80);
      commit();
      wait_lvl(0, 1'b1, 2000);
      for (int i = 0; i < 7; i++) begin
         pulse_cond(7'h1 << i, 1 + int'(xs() % 3));
         wait_lvl(0, 1'b0, 2000);
         repeat (5) @(posedge pclk);
         rd(ADDR_FLAGS, 32'h1 << i);
         commit();
         wait_lvl(0, 1'b1, 2000);
      end
      wr(ADDR_MASK, 32'hff);
      rd(ADDR_MASK, 32'hff);
      commit();
      pulse_cond(7'h01, 2);
      repeat (20) @(posedge pclk);
      wait_lvl(0, 1'b1, 1);
      wr(ADDR_MASK, 32'h0);
      commit();
      wait_lvl(0, 1'b0, 2000);
      rd(ADDR_FLAGS, 32'h1);
      commit();
      wait_lvl(0, 1'b1, 2000);
      host.set_pins(1'b1, 1'b0);
      wait_lvl(1, 1'b0, 2000);
      host.set_pins(1'b0, 1'b0);
      wait_lvl(1, 1'b1, 2000);
      wr(ADDR_CONTROL, 32'h1);
      rd(ADDR_CONTROL, 32'h1);
      commit();
      wait_lvl(2, 1'b1, 2000);
      rd(ADDR_STATUS, 32'h86);
      wr(ADDR_CONTROL, 32'h0);
      commit();
      wait_lvl(2, 1'b0, 2000);
      rd(ADDR_STATUS, 32'h44);
      host.reset_pulse(30);
      repeat (10) @(posedge pclk);
      rd(ADDR_STATUS, 32'h44);
      host.set_pins(1'b0, 1'b1);
      wait_lvl(2, 1'b1, 2000);
      host.set_pins(1'b0, 1'b0);
      fork
         host.reset_pulse(60);
         begin
            repeat (52) @(posedge pclk);
            rd(ADDR_STATUS, 32'h11);
         end
      join
      wait_lvl(0, 1'b0, INIT_N + 100);
      rd(ADDR_STATUS, 32'h44);
      rd(ADDR_IRQ_ST, 32'hf);
      repeat (2) @(posedge pclk);
      check(exp_q.size(), 32'h0, "pending transfers");
      tally_and_finish();
   end
endmodule
